// ### dsr_pkg.sv
// Constants shared by the dual supply reset generator
package dsr_pkg;
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned HOLD_TIME_MS = 180;
	localparam int unsigned MS_PER_S = 1000;
	// Hold time in clock cycles, rounded down (longest time, approximate by nature)
	localparam int unsigned HOLD_CYCLES_DEF = HOLD_TIME_MS * (CLK_HZ / MS_PER_S);
	localparam int unsigned CNT_W = 23;
	// Cycles the reset pin input is ignored after the device stops pulling it low
	localparam int unsigned BLANK_CYCLES = 4;
	localparam int unsigned BLANK_W = 3;
	localparam logic SYNC_RST = 1'b0;
endpackage

// ### dsr_hold_if.sv
// Carrier between the reset generator and one hold timer
`timescale 1ns/10ps
interface dsr_hold_if;
	logic hold;
	logic done;
	modport timer (input hold, output done);
	modport user (output hold, input done);
endinterface

// ### dsr_hold_timer.sv
// Hold period counter: done rises a fixed number of cycles after hold falls
`timescale 1ns/10ps
module dsr_hold_timer #(
	parameter int unsigned HOLD_CYCLES = dsr_pkg::HOLD_CYCLES_DEF
) (
	input wire logic i_clk, // System clock
	input wire logic i_rst, // Asynchronous reset, active high
	dsr_hold_if.timer hif // Hold request in, expiry out
);
	import dsr_pkg::*;

	typedef struct packed {
		logic [CNT_W-1:0] count;
		logic done;
	} dsr_timer_state_type;

	localparam logic [CNT_W-1:0] LAST = CNT_W'(HOLD_CYCLES - 1);

	dsr_timer_state_type st;
	dsr_timer_state_type next_st;

	always_comb begin
		next_st = st;
		if (hif.hold) begin
			// A new drop of the supply restarts the whole period
			next_st.count = '0;
			next_st.done = 1'b0;
		end else if (!st.done) begin
			next_st.count = st.count + CNT_W'(1);
			if (st.count == LAST) begin
				next_st.done = 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign hif.done = st.done;
endmodule

// ### dsr_reset_gen.sv
// Dual supply power-on reset generator with bidirectional main reset pin
`timescale 1ns/10ps
module dsr_reset_gen #(
	parameter int unsigned HOLD_CYCLES = dsr_pkg::HOLD_CYCLES_DEF
) (
	input wire logic I_CLK, // 25 MHz system clock
	input wire logic I_SYS_RST, // Asynchronous reset, active high
	input wire logic I_STANDBY_SUPPLY_GOOD, // Standby rail above threshold
	input wire logic I_MAIN_SUPPLY_GOOD, // Main rail above threshold
	input wire logic I_MAIN_RESET_N, // Level seen on the main reset pin
	output logic O_MAIN_RESET_N, // Level driven on the main reset pin
	output logic O_MAIN_RESET_OE, // High while the pin is pulled low
	output logic O_STANDBY_RESET_N, // Standby power-on reset, active low
	output logic O_EXT_RESET_REQ // Outside low seen on the main reset pin
);
	import dsr_pkg::*;

	// Depth of the synchronisers on the asynchronous inputs
	localparam int unsigned SYNC_STAGES = 2;
	localparam int unsigned SYNC_OUT = SYNC_STAGES - 1;

	localparam logic [BLANK_W-1:0] BLANK_LOAD = BLANK_W'(BLANK_CYCLES);
	localparam logic [BLANK_W-1:0] BLANK_STEP = BLANK_W'(1);
	localparam logic [BLANK_W-1:0] BLANK_DONE = '0;

	// The pin is open drain: the only level ever driven onto it is low
	localparam logic PIN_DRIVE_LEVEL = 1'h0;
	localparam logic RESET_ASSERTED = 1'h0;
	localparam logic RESET_RELEASED = 1'h1;
	localparam logic PIN_PULLED = 1'h1;
	localparam logic PIN_LEFT = 1'h0;
	localparam logic REQ_SEEN = 1'h1;
	localparam logic REQ_NONE = 1'h0;

	typedef struct packed {
		logic [SYNC_STAGES-1:0] stby_sync;
		logic [SYNC_STAGES-1:0] main_sync;
		logic [SYNC_STAGES-1:0] pin_sync;
		logic stby_reset_n;
		logic main_oe;
		logic main_level;
		logic [BLANK_W-1:0] blank;
		logic ext_req;
	} dsr_top_state_type;

	dsr_top_state_type st;
	dsr_top_state_type next_st;

	// Settled views of the asynchronous inputs
	logic stby_good;
	logic main_good;
	logic pin_high;

	// Main hold period has run out with nothing holding it back
	logic main_release;

	// Device has let go of the pin and the pin has had time to rise
	logic pin_listen;

	dsr_hold_if stby_hif ();
	dsr_hold_if main_hif ();

	// Comparator outputs and the reset pin are asynchronous, so only the last stage is read
	assign stby_good = st.stby_sync[SYNC_OUT];
	assign main_good = st.main_sync[SYNC_OUT];
	assign pin_high = st.pin_sync[SYNC_OUT];

	assign stby_hif.hold = !stby_good;

	// Main period cannot start until standby reset has been released
	assign main_hif.hold = !main_good || !st.stby_reset_n;

	assign main_release = main_hif.done && !main_hif.hold;

	assign pin_listen = !st.main_oe && (st.blank == BLANK_DONE);

	dsr_hold_timer #(
		.HOLD_CYCLES(HOLD_CYCLES)
	) u_stby_timer (
		.i_clk(I_CLK),
		.i_rst(I_SYS_RST),
		.hif(stby_hif)
	);

	dsr_hold_timer #(
		.HOLD_CYCLES(HOLD_CYCLES)
	) u_main_timer (
		.i_clk(I_CLK),
		.i_rst(I_SYS_RST),
		.hif(main_hif)
	);

	always_comb begin
		next_st = st;

		next_st.stby_sync = {st.stby_sync[0], I_STANDBY_SUPPLY_GOOD};
		next_st.main_sync = {st.main_sync[0], I_MAIN_SUPPLY_GOOD};
		next_st.pin_sync = {st.pin_sync[0], I_MAIN_RESET_N};

		// Reset drops at once on a bad supply; only the release waits for the hold
		if (!stby_good) begin
			next_st.stby_reset_n = RESET_ASSERTED;
		end else if (stby_hif.done) begin
			next_st.stby_reset_n = RESET_RELEASED;
		end else begin
			next_st.stby_reset_n = RESET_ASSERTED;
		end

		if (main_release) begin
			next_st.main_oe = PIN_LEFT;
		end else begin
			next_st.main_oe = PIN_PULLED;
		end

		next_st.main_level = PIN_DRIVE_LEVEL;

		// Our own low drains through the synchroniser after release; blank it
		if (st.main_oe) begin
			next_st.blank = BLANK_LOAD;
		end else if (st.blank != BLANK_DONE) begin
			next_st.blank = st.blank - BLANK_STEP;
		end

		// Only reported: feeding it back into the timers would latch our own low
		if (pin_listen && !pin_high) begin
			next_st.ext_req = REQ_SEEN;
		end else begin
			next_st.ext_req = REQ_NONE;
		end
	end

	always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			st.stby_sync <= {SYNC_STAGES{SYNC_RST}};
			st.main_sync <= {SYNC_STAGES{SYNC_RST}};
			st.pin_sync <= {SYNC_STAGES{SYNC_RST}};
			st.stby_reset_n <= RESET_ASSERTED;
			st.main_oe <= PIN_PULLED;
			st.main_level <= PIN_DRIVE_LEVEL;
			st.blank <= BLANK_LOAD;
			st.ext_req <= REQ_NONE;
		end else begin
			st <= next_st;
		end
	end

	assign O_MAIN_RESET_N = st.main_level;
	assign O_MAIN_RESET_OE = st.main_oe;
	assign O_STANDBY_RESET_N = st.stby_reset_n;
	assign O_EXT_RESET_REQ = st.ext_req;
endmodule

// ### dsr_partner.sv
// System side of the main reset pin with its pull-up
`timescale 1ns/10ps
module dsr_partner (
	input wire logic i_oe, // Device pulls low
	input wire logic i_pull_low, // System reset request
	output logic o_pin // Wire level
);
	// Pull-up wins when nobody drives
	assign o_pin = !(i_oe || i_pull_low);
endmodule

// ### dsr_asserts.sv
// Pin checks for the reset generator
`timescale 1ns/10ps
module dsr_asserts #(parameter int unsigned HOLD_CYCLES = 20) (
	input wire logic I_CLK, // i
	input wire logic I_SYS_RST, // i
	input wire logic I_STANDBY_SUPPLY_GOOD, // i
	input wire logic I_MAIN_SUPPLY_GOOD, // i
	input wire logic I_MAIN_RESET_N, // i
	input wire logic O_MAIN_RESET_OE, // o
	input wire logic O_STANDBY_RESET_N, // o
	input wire logic O_EXT_RESET_REQ // o
);
	localparam int unsigned H = HOLD_CYCLES;
	int unsigned cs, cm, cr;
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_SYS_RST);
	// Runs of good supply and released standby reset
	always_ff @(posedge I_CLK) cs <= (I_STANDBY_SUPPLY_GOOD && !I_SYS_RST) ? cs + 1 : 0;
	always_ff @(posedge I_CLK) cm <= (I_MAIN_SUPPLY_GOOD && !I_SYS_RST) ? cm + 1 : 0;
	always_ff @(posedge I_CLK) cr <= (O_STANDBY_RESET_N && !I_SYS_RST) ? cr + 1 : 0;
	sequence s_sb_bad; !I_STANDBY_SUPPLY_GOOD [*5]; endsequence
	sequence s_mn_bad; !I_MAIN_SUPPLY_GOOD [*5]; endsequence
	sequence s_ext; (!I_MAIN_RESET_N && !O_MAIN_RESET_OE) [*8]; endsequence
	AST_SB_LOW: assert property (s_sb_bad |-> !O_STANDBY_RESET_N)
		else $error("sb low");
	AST_SB_HOLD: assert property ($rose(O_STANDBY_RESET_N) |-> cs >= H)
		else $error("sb early");
	AST_SB_REL: assert property (cs == H + 6 |-> O_STANDBY_RESET_N)
		else $error("sb late");
	AST_MN_LOW: assert property (s_mn_bad |-> O_MAIN_RESET_OE)
		else $error("mn low");
	AST_MN_HOLD: assert property ($fell(O_MAIN_RESET_OE) |-> cm >= H)
		else $error("mn early");
	AST_MN_ORD: assert property ($fell(O_MAIN_RESET_OE) |-> cr >= H)
		else $error("mn order");
	AST_MN_REL: assert property (cm > H + 6 && cr > H + 6 |-> !O_MAIN_RESET_OE)
		else $error("mn late");
	AST_EXT: assert property (s_ext |-> O_EXT_RESET_REQ)
		else $error("ext");
endmodule
bind dsr_reset_gen dsr_asserts #(.HOLD_CYCLES(HOLD_CYCLES)) i_chk (.I_CLK(I_CLK),
	.I_SYS_RST(I_SYS_RST), .I_STANDBY_SUPPLY_GOOD(I_STANDBY_SUPPLY_GOOD),
	.I_MAIN_SUPPLY_GOOD(I_MAIN_SUPPLY_GOOD), .I_MAIN_RESET_N(I_MAIN_RESET_N),
	.O_MAIN_RESET_OE(O_MAIN_RESET_OE), .O_STANDBY_RESET_N(O_STANDBY_RESET_N),
	.O_EXT_RESET_REQ(O_EXT_RESET_REQ));

// ### tb.sv
// Bench for the reset generator
`timescale 1ns/10ps
module tb;
	localparam int H = 20;
	logic clk = 0, rst = 1, sg = 0, mg = 0, pl = 0;
	logic pin, oe, srn, req, drv;
	int err_total = 0, checks_done = 0, g;
	dsr_reset_gen #(.HOLD_CYCLES(H)) i_dut (.I_CLK(clk), .I_SYS_RST(rst),
		.I_STANDBY_SUPPLY_GOOD(sg), .I_MAIN_SUPPLY_GOOD(mg), .I_MAIN_RESET_N(pin),
		.O_MAIN_RESET_N(drv), .O_MAIN_RESET_OE(oe), .O_STANDBY_RESET_N(srn),
		.O_EXT_RESET_REQ(req));
	dsr_partner i_sys (.i_oe(oe), .i_pull_low(pl), .o_pin(pin));
	initial forever #20 clk = ~clk;
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string n, input logic e, input logic a);
		checks_done++;
		if (a !== e) begin
			err_total++;
			$display("MISMATCH %s exp %b got %b", n, e, a);
		end
	endtask
	// Standby reset is released three edges after the hold count ends
	function automatic logic srn_exp(input int n);
		return n >= H + 3;
	endfunction
	task automatic end_of_test;
		if (err_total == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		void'($urandom(32'h3BEDA053));
		cyc(8);
		rst = 0;
		sg = 1;
		mg = 1;
		cyc(H);
		chk("srn", srn_exp(H), srn);
		chk("drv", 0, drv);
		cyc(6);
		chk("srn", srn_exp(H + 6), srn);
		cyc(H - 4);
		chk("oe", 1, oe);
		cyc(8);
		chk("oe", 0, oe);
		sg = 0;
		cyc(6);
		chk("srn", 0, srn);
		sg = 1;
		// One-cycle dip at a random point of the hold
		g = 6 + $urandom % (H - 8);
		cyc(g);
		sg = 0;
		cyc(1);
		sg = 1;
		cyc(H - 1);
		chk("srn", 0, srn);
		cyc(2 * H + 12);
		chk("oe", 0, oe);
		mg = 0;
		cyc(5);
		chk("oe", 1, oe);
		mg = 1;
		cyc(H - 1);
		chk("oe", 1, oe);
		cyc(8);
		pl = 1;
		cyc(8);
		chk("req", 1, req);
		chk("drv", 0, drv);
		pl = 0;
		cyc(8);
		chk("req", 0, req);
		end_of_test;
	end
	initial begin
		cyc(8 * H + 200);
		err_total++;
		end_of_test;
	end
endmodule
